// File: logic/gpio_port_with_edge_wakeup.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// [RULE1] direction bit 0 makes the pin input, 1 makes it push-pull output
// [RULE2] an output pin drives the level held in its value bit
// [RULE3] an input pin gets weak pull-up when value bit is 1, else high-Z
// [RULE4] direction and output-value registers are writable and read back
// [RULE5] input-sense read returns every pin level whatever its setting
// [RULE6] power-up clears direction and value; pins 0 and 5 may take straps
// [RULE7] reset clears wake enable, edge select, pending, timer-zero control
// [RULE8] bit n of each wake register serves pin n
// [RULE9] pending may set only while the pin's wake enable is 1
// [RULE10] edge select 1 picks falling edges, 0 picks rising edges
// [RULE11] pending stays 1 after its edge until software clears it
// [RULE12] OR of flags drives wake-out in halt or idle and the shared irq
// [RULE13] shared edge irq needs the wake irq enable bit at 1
// [RULE14] halt or idle requests are ignored while any flag is pending
// [RULE15] shared edge irq holds while any flag is set
// [RULE16] writing 0 clears a pending bit, writing 1 keeps it
// [RULE17] trip wake select at 1 puts comparator trip on wake bit 6
// [RULE18] edge wake works the same for input and output pins
// [RULE19] timer-zero control at 0xB6: bit 7 wake irq, bits 1 and 0 timer
// [RULE20] wake sources are synchronised; edges compare consecutive samples
// [RULE21] an edge in the cycle of a clearing write keeps the flag set
module gpio_port_with_edge_wakeup (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register bus from the core
  input wire gpio_wake_pkg::bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  // initialization straps for pins 0 and 5, index 0 is pin 0
  input wire logic [1:0] strap_direction,
  input wire logic [1:0] strap_output_value,
  // pads
  input wire logic [gpio_wake_pkg::PIN_COUNT-1:0] pad_in,
  output gpio_wake_pkg::pad_ctrl_t pad_ctrl,
  // comparator trip and its wake select from the dead delay register
  input wire logic comparator_trip,
  input wire logic trip_wake_select,
  // timer zero overflow event from the counter
  input wire logic timer_zero_overflow,
  // power mode requests from the core and idle timer wake
  input wire logic halt_request,
  input wire logic idle_request,
  input wire logic idle_timer_wake,
  // status towards the core
  output logic wake_out_a,
  output logic shared_edge_irq,
  output logic timer_zero_irq,
  output logic halt_active,
  output logic idle_active
);

  localparam int N = gpio_wake_pkg::PIN_COUNT;

  // software visible storage
  logic [N-1:0] pin_direction_reg;
  logic [N-1:0] pin_direction_next;
  logic [N-1:0] pin_output_value_reg;
  logic [N-1:0] pin_output_value_next;
  logic [N-1:0] wake_edge_select_reg;
  logic [N-1:0] wake_edge_select_next;
  logic [N-1:0] wake_enable_mask_reg;
  logic [N-1:0] wake_enable_mask_next;
  logic wake_irq_enable_reg;
  logic wake_irq_enable_next;
  logic timer_zero_pending_reg;
  logic timer_zero_pending_next;
  logic timer_zero_irq_enable_reg;
  logic timer_zero_irq_enable_next;

  // pad side and wake path
  gpio_wake_pkg::pad_ctrl_t pad_ctrl_reg;
  gpio_wake_pkg::pad_ctrl_t pad_ctrl_next;
  logic [N-1:0] pin_level;
  logic [N-1:0] wake_source;
  logic [N-1:0] wake_pending_flags;
  logic [N-1:0] pending_clear;
  logic any_pending;
  logic trip_select_reg;
  logic [N-1:0] source_swap;

  // bus read path
  logic [7:0] bus_rdata_reg;
  logic [7:0] bus_rdata_next;
  logic bus_rvalid_reg;
  logic [7:0] read_mux;
  logic [7:0] timer_zero_control_view;

  // power mode and status outputs
  gpio_wake_pkg::power_mode_t mode_reg;
  gpio_wake_pkg::power_mode_t mode_next;
  logic wake_out_a_reg;
  logic wake_out_a_next;
  logic shared_edge_irq_reg;
  logic shared_edge_irq_next;
  logic timer_zero_irq_reg;
  logic timer_zero_irq_next;

  // address decode
  wire wr_edge = bus_req.wr &
    (bus_req.addr == gpio_wake_pkg::ADDR_WAKE_EDGE_SELECT);
  wire wr_pend = bus_req.wr &
    (bus_req.addr == gpio_wake_pkg::ADDR_WAKE_PENDING_FLAGS);
  wire wr_enab = bus_req.wr &
    (bus_req.addr == gpio_wake_pkg::ADDR_WAKE_ENABLE_MASK);
  wire wr_oval = bus_req.wr &
    (bus_req.addr == gpio_wake_pkg::ADDR_PIN_OUTPUT_VALUE);
  wire wr_dir = bus_req.wr &
    (bus_req.addr == gpio_wake_pkg::ADDR_PIN_DIRECTION);
  wire wr_tzc = bus_req.wr &
    (bus_req.addr == gpio_wake_pkg::ADDR_TIMER_ZERO_CONTROL);

  // register writes; the input-sense address takes no write
  assign pin_direction_next =
    wr_dir ? bus_req.wdata : pin_direction_reg; // [RULE4] [RULE1]
  assign pin_output_value_next =
    wr_oval ? bus_req.wdata : pin_output_value_reg; // [RULE4]
  assign wake_edge_select_next =
    wr_edge ? bus_req.wdata : wake_edge_select_reg;
  assign wake_enable_mask_next =
    wr_enab ? bus_req.wdata : wake_enable_mask_reg;
  assign wake_irq_enable_next = wr_tzc ?
    bus_req.wdata[gpio_wake_pkg::TZC_WAKE_IRQ_ENABLE] :
    wake_irq_enable_reg; // [RULE19]
  assign timer_zero_irq_enable_next = wr_tzc ?
    bus_req.wdata[gpio_wake_pkg::TZC_TIMER_ZERO_IRQ_ENABLE] :
    timer_zero_irq_enable_reg; // [RULE19]
  // the overflow event beats a software write of the same cycle
  assign timer_zero_pending_next = timer_zero_overflow | (wr_tzc ?
    bus_req.wdata[gpio_wake_pkg::TZC_TIMER_ZERO_PENDING] :
    timer_zero_pending_reg); // [RULE19]

  // a zero in the written byte clears that flag, a one holds it
  assign pending_clear = wr_pend ? ~bus_req.wdata : '0; // [RULE16]

  // pad drive: output pins drive their value, inputs may pull up
  assign pad_ctrl_next.drive_en = pin_direction_reg; // [RULE1]
  assign pad_ctrl_next.drive_val = pin_output_value_reg; // [RULE2]
  assign pad_ctrl_next.pullup_en =
    ~pin_direction_reg & pin_output_value_reg; // [RULE3]

  // per-pin wake path; the pad level is sensed even while driven, so an
  // output pin wakes like an input
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_pin
      pin_level_filter u_filter (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pad_level(pad_in[gi]),
        .level(pin_level[gi])
      ); // [RULE20] [RULE18]
      if (gi == gpio_wake_pkg::TRIP_WAKE_BIT) begin : g_trip
        // the trip comes from logic on mclk, so it needs no synchroniser;
        // the edge seen in the cycle the select flips is only the swap of
        // sources, so that cycle is masked, at the cost of a real trip
        // landing in the same cycle
        assign wake_source[gi] =
          trip_wake_select ? comparator_trip : pin_level[gi]; // [RULE17]
        assign source_swap[gi] =
          trip_wake_select ^ trip_select_reg; // [RULE17]
      end else begin : g_plain
        assign wake_source[gi] = pin_level[gi];
        assign source_swap[gi] = 1'b0;
      end
      wake_pending_cell u_cell (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .source(wake_source[gi]),
        .enable(wake_enable_mask_reg[gi] & ~source_swap[gi]),
        .falling_sel(wake_edge_select_reg[gi]),
        .clear(pending_clear[gi]),
        .pending(wake_pending_flags[gi])
      ); // [RULE8] [RULE9] [RULE10] [RULE11] [RULE20] [RULE21]
    end
  endgenerate

  assign any_pending = |wake_pending_flags; // [RULE12]

  // read mux; unmapped addresses read zero
  assign timer_zero_control_view = {
    wake_irq_enable_reg,
    5'h00,
    timer_zero_pending_reg,
    timer_zero_irq_enable_reg
  };
  assign read_mux =
    (bus_req.addr == gpio_wake_pkg::ADDR_WAKE_EDGE_SELECT) ?
      wake_edge_select_reg :
    (bus_req.addr == gpio_wake_pkg::ADDR_WAKE_PENDING_FLAGS) ?
      wake_pending_flags :
    (bus_req.addr == gpio_wake_pkg::ADDR_WAKE_ENABLE_MASK) ?
      wake_enable_mask_reg :
    (bus_req.addr == gpio_wake_pkg::ADDR_PIN_OUTPUT_VALUE) ?
      pin_output_value_reg : // [RULE4]
    (bus_req.addr == gpio_wake_pkg::ADDR_PIN_DIRECTION) ?
      pin_direction_reg : // [RULE4]
    (bus_req.addr == gpio_wake_pkg::ADDR_PIN_INPUT_SENSE) ?
      pin_level : // [RULE5]
    (bus_req.addr == gpio_wake_pkg::ADDR_TIMER_ZERO_CONTROL) ?
      timer_zero_control_view :
      8'h00;
  // data stays until the next read so the core may sample it late
  assign bus_rdata_next = bus_req.rd ? read_mux : bus_rdata_reg;

  // power mode sequencing
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      gpio_wake_pkg::MODE_RUN: begin
        // entering with a flag set would sleep through a pending wake
        if (!any_pending && halt_request) begin
          mode_next = gpio_wake_pkg::MODE_HALT; // [RULE14]
        end else if (!any_pending && idle_request) begin
          mode_next = gpio_wake_pkg::MODE_IDLE; // [RULE14]
        end
      end
      gpio_wake_pkg::MODE_HALT: begin
        if (any_pending) begin
          mode_next = gpio_wake_pkg::MODE_RUN;
        end
      end
      gpio_wake_pkg::MODE_IDLE: begin
        if (any_pending || idle_timer_wake) begin
          mode_next = gpio_wake_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_next = gpio_wake_pkg::MODE_RUN;
      end
    endcase
  end

  wire in_low_power = (mode_reg != gpio_wake_pkg::MODE_RUN);

  assign wake_out_a_next = any_pending & in_low_power; // [RULE12]
  // follows the flags every cycle while the wake irq enable is 1, so it holds while any remains
  assign shared_edge_irq_next =
    any_pending & wake_irq_enable_reg; // [RULE12] [RULE13] [RULE15]
  assign timer_zero_irq_next =
    timer_zero_pending_reg & timer_zero_irq_enable_reg;

  // configuration storage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_direction_reg <= gpio_wake_pkg::RST_PIN_REGS; // [RULE6]
      pin_output_value_reg <= gpio_wake_pkg::RST_PIN_REGS; // [RULE6]
      // strapped pins take their initialization setting instead
      pin_direction_reg[gpio_wake_pkg::STRAP_PIN_A] <=
        strap_direction[0]; // [RULE6]
      pin_direction_reg[gpio_wake_pkg::STRAP_PIN_B] <=
        strap_direction[1]; // [RULE6]
      pin_output_value_reg[gpio_wake_pkg::STRAP_PIN_A] <=
        strap_output_value[0]; // [RULE6]
      pin_output_value_reg[gpio_wake_pkg::STRAP_PIN_B] <=
        strap_output_value[1]; // [RULE6]
    end else begin
      pin_direction_reg <= pin_direction_next;
      pin_output_value_reg <= pin_output_value_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wake_edge_select_reg <= gpio_wake_pkg::RST_WAKE_REGS; // [RULE7]
      wake_enable_mask_reg <= gpio_wake_pkg::RST_WAKE_REGS; // [RULE7]
      wake_irq_enable_reg <=
        gpio_wake_pkg::RST_TIMER_ZERO_CONTROL[
          gpio_wake_pkg::TZC_WAKE_IRQ_ENABLE]; // [RULE7]
      timer_zero_pending_reg <=
        gpio_wake_pkg::RST_TIMER_ZERO_CONTROL[
          gpio_wake_pkg::TZC_TIMER_ZERO_PENDING]; // [RULE7]
      timer_zero_irq_enable_reg <=
        gpio_wake_pkg::RST_TIMER_ZERO_CONTROL[
          gpio_wake_pkg::TZC_TIMER_ZERO_IRQ_ENABLE]; // [RULE7]
    end else begin
      wake_edge_select_reg <= wake_edge_select_next;
      wake_enable_mask_reg <= wake_enable_mask_next;
      wake_irq_enable_reg <= wake_irq_enable_next;
      timer_zero_pending_reg <= timer_zero_pending_next;
      timer_zero_irq_enable_reg <= timer_zero_irq_enable_next;
    end
  end

  // pads and bus answer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pad_ctrl_reg <= '0;
      bus_rdata_reg <= gpio_wake_pkg::RST_READ_DATA;
      bus_rvalid_reg <= 1'b0;
    end else begin
      pad_ctrl_reg <= pad_ctrl_next;
      bus_rdata_reg <= bus_rdata_next;
      bus_rvalid_reg <= bus_req.rd;
    end
  end

  // mode and status
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_reg <= gpio_wake_pkg::MODE_RUN;
      wake_out_a_reg <= 1'b0;
      shared_edge_irq_reg <= 1'b0;
      timer_zero_irq_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      wake_out_a_reg <= wake_out_a_next;
      shared_edge_irq_reg <= shared_edge_irq_next;
      timer_zero_irq_reg <= timer_zero_irq_next;
    end
  end

  // last select, to spot the cycle in which the bit 6 source swaps
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trip_select_reg <= 1'b0;
    end else begin
      trip_select_reg <= trip_wake_select;
    end
  end

  logic halt_active_reg;
  logic idle_active_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      halt_active_reg <= 1'b0;
      idle_active_reg <= 1'b0;
    end else begin
      halt_active_reg <= (mode_next == gpio_wake_pkg::MODE_HALT);
      idle_active_reg <= (mode_next == gpio_wake_pkg::MODE_IDLE);
    end
  end

  assign pad_ctrl = pad_ctrl_reg;
  assign bus_rdata = bus_rdata_reg;
  assign bus_rvalid = bus_rvalid_reg;
  assign wake_out_a = wake_out_a_reg;
  assign shared_edge_irq = shared_edge_irq_reg;
  assign timer_zero_irq = timer_zero_irq_reg;
  assign halt_active = halt_active_reg;
  assign idle_active = idle_active_reg;

endmodule
`default_nettype wire

// File: logic/gpio_wake_pkg.sv
`default_nettype none
package gpio_wake_pkg;

  localparam int PIN_COUNT = 8;

  // register byte addresses on the core's data bus
  localparam logic [7:0] ADDR_WAKE_EDGE_SELECT = 8'hAF;
  localparam logic [7:0] ADDR_WAKE_PENDING_FLAGS = 8'hB0;
  localparam logic [7:0] ADDR_WAKE_ENABLE_MASK = 8'hB1;
  localparam logic [7:0] ADDR_PIN_OUTPUT_VALUE = 8'hB2;
  localparam logic [7:0] ADDR_PIN_DIRECTION = 8'hB3;
  localparam logic [7:0] ADDR_PIN_INPUT_SENSE = 8'hB4;
  localparam logic [7:0] ADDR_TIMER_ZERO_CONTROL = 8'hB6;

  // reset values
  localparam logic [7:0] RST_PIN_REGS = 8'h00;
  localparam logic [7:0] RST_WAKE_REGS = 8'h00;
  localparam logic [7:0] RST_TIMER_ZERO_CONTROL = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // pins whose power-up setting may come from the initialization straps
  localparam int STRAP_PIN_A = 0;
  localparam int STRAP_PIN_B = 5;

  // wake bit position that the comparator trip can take over
  localparam int TRIP_WAKE_BIT = 6;

  // timer-zero control field positions
  localparam int TZC_WAKE_IRQ_ENABLE = 7;
  localparam int TZC_TIMER_ZERO_PENDING = 1;
  localparam int TZC_TIMER_ZERO_IRQ_ENABLE = 0;

  // register bus request from the core
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } bus_req_t;

  // per-port pad control, one bit per pin
  typedef struct packed {
    logic [PIN_COUNT-1:0] drive_en;
    logic [PIN_COUNT-1:0] drive_val;
    logic [PIN_COUNT-1:0] pullup_en;
  } pad_ctrl_t;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_HALT,
    MODE_IDLE
  } power_mode_t;

endpackage
`default_nettype wire

// File: logic/pin_level_filter.sv
`timescale 1ns/10ps
`default_nettype none
module pin_level_filter (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // raw pad level
  input wire logic pad_level,
  // filtered level on mclk
  output logic level
);

  logic meta_reg;
  logic sync_reg;
  logic late_reg;
  logic level_reg;
  logic level_next;

  // stage one is seen only by stage two; the level moves once two and
  // three agree, which rejects a single-cycle glitch
  assign level_next = (sync_reg == late_reg) ? late_reg : level_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      late_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      meta_reg <= pad_level;
      sync_reg <= meta_reg;
      late_reg <= sync_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule
`default_nettype wire

// File: logic/wake_pending_cell.sv
`timescale 1ns/10ps
`default_nettype none
module wake_pending_cell (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // wake source, already on mclk
  input wire logic source,
  // configuration
  input wire logic enable,
  input wire logic falling_sel,
  // software clear strobe
  input wire logic clear,
  // sticky flag
  output logic pending
);

  logic prev_reg;
  logic pending_reg;
  logic pending_next;
  wire rise = source & ~prev_reg;
  wire fall = ~source & prev_reg;
  wire hit = enable & (falling_sel ? fall : rise);

  // set is ORed in after the clear so a same-cycle edge survives
  assign pending_next = (pending_reg & ~clear) | hit;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prev_reg <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      prev_reg <= source;
      pending_reg <= pending_next;
    end
  end

  assign pending = pending_reg;

endmodule
`default_nettype wire

// File: dv/pad_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module pad_board_model (
  // clock
  input wire logic mclk,
  // pad control from the port
  input wire gpio_wake_pkg::pad_ctrl_t pad_ctrl,
  // board drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // resolved pad levels
  output logic [7:0] pad_level
);
  logic [7:0] held = 8'h00;
  wire [7:0] ext_on = ~pad_ctrl.drive_en & ext_en;
  wire [7:0] pulled = ~pad_ctrl.drive_en & ~ext_en & pad_ctrl.pullup_en;
  wire [7:0] driven = pad_ctrl.drive_en | ext_on | pulled;
  // a floating pad shows the inverse of its last level, never a kind value
  assign pad_level = (pad_ctrl.drive_en & pad_ctrl.drive_val) |
    (ext_on & ext_val) | pulled | (~driven & ~held);
  always @(posedge mclk) held <= (driven & pad_level) | (~driven & held);
endmodule
`default_nettype wire

// File: dv/gpio_port_with_edge_wakeup_chk.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_port_with_edge_wakeup_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register bus
  input wire gpio_wake_pkg::bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  // pads and status
  input wire gpio_wake_pkg::pad_ctrl_t pad_ctrl,
  input wire logic halt_request,
  input wire logic wake_out_a,
  input wire logic shared_edge_irq,
  input wire logic halt_active,
  input wire logic idle_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire wr_dir = bus_req.wr && bus_req.addr == 8'hB3;
  wire wr_val = bus_req.wr && bus_req.addr == 8'hB2;
  wire wr_pend = bus_req.wr && bus_req.addr == 8'hB0;
  wire wr_tzc = bus_req.wr && bus_req.addr == 8'hB6;
  // pad control trails the register by one more edge
  property p_dir;
    wr_dir ##1 !wr_dir |=> pad_ctrl.drive_en == $past(bus_req.wdata, 2);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction not on pads");
  property p_val;
    wr_val ##1 !wr_val |=> pad_ctrl.drive_val == $past(bus_req.wdata, 2);
  endproperty
  a_val: assert property (p_val) else $error("value not on pads");
  property p_pull;
    pad_ctrl.pullup_en == (~pad_ctrl.drive_en & pad_ctrl.drive_val);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up wrong");
  property p_unmapped;
    bus_req.rd && bus_req.addr == 8'hB5 |=> bus_rvalid && bus_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("bad unmapped");
  property p_irq_off;
    wr_tzc && !bus_req.wdata[7] |=> ##1 !shared_edge_irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq not masked");
  property p_halt_ref;
    halt_request && shared_edge_irq && !$past(wr_pend) && !halt_active &&
      !idle_active |=> !halt_active;
  endproperty
  a_halt_ref: assert property (p_halt_ref)
    else $error("halt taken");
  property p_halt_src;
    $rose(halt_active) |-> $past(halt_request);
  endproperty
  a_halt_src: assert property (p_halt_src)
    else $error("halt unasked");
  property p_irq_hold;
    shared_edge_irq && !$past(wr_pend) && !$past(wr_tzc) |=> shared_edge_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped");
  property p_wake;
    wake_out_a |-> $past(halt_active || idle_active);
  endproperty
  a_wake: assert property (p_wake) else $error("wake out in run");
  c_irq: cover property (shared_edge_irq ##1 !shared_edge_irq);
  c_halt: cover property ($rose(halt_active));
  c_wake: cover property (wake_out_a);
endmodule
bind gpio_port_with_edge_wakeup gpio_port_with_edge_wakeup_chk u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .bus_rvalid(bus_rvalid), .pad_ctrl(pad_ctrl), .halt_request(halt_request),
  .wake_out_a(wake_out_a), .shared_edge_irq(shared_edge_irq),
  .halt_active(halt_active), .idle_active(idle_active));
`default_nettype wire

// File: dv/test_gpio_port_with_edge_wakeup.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH at %0t: got %h exp %h", $time, g, e); end end
module test_gpio_port_with_edge_wakeup;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
  row_t rows [6] = '{'{8'hB3, 8'h5A, 8'h5A}, '{8'hB2, 8'hA5, 8'hA5},
    '{8'hAF, 8'h3C, 8'h3C}, '{8'hB1, 8'h00, 8'h00},
    '{8'hB6, 8'h7C, 8'h00}, '{8'hB5, 8'h77, 8'h00}};
  logic mclk, sys_rst, comparator_trip, trip_wake_select, idle_timer_wake;
  logic halt_request, idle_request, bus_rvalid, wake_out_a, shared_edge_irq;
  logic timer_zero_irq, halt_active, idle_active, timer_zero_overflow;
  logic [1:0] strap_direction, strap_output_value;
  logic [7:0] bus_rdata, pad_in, ext_en, ext_val;
  gpio_wake_pkg::bus_req_t bus_req;
  gpio_wake_pkg::pad_ctrl_t pad_ctrl;
  int miscompares, tests_run, cycles, k;
  gpio_port_with_edge_wakeup u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .strap_direction(strap_direction), .strap_output_value(strap_output_value),
    .pad_in(pad_in), .pad_ctrl(pad_ctrl), .comparator_trip(comparator_trip),
    .trip_wake_select(trip_wake_select),
    .timer_zero_overflow(timer_zero_overflow), .halt_request(halt_request),
    .idle_request(idle_request), .idle_timer_wake(idle_timer_wake),
    .wake_out_a(wake_out_a), .shared_edge_irq(shared_edge_irq),
    .timer_zero_irq(timer_zero_irq), .halt_active(halt_active),
    .idle_active(idle_active));
  pad_board_model u_board (.mclk(mclk), .pad_ctrl(pad_ctrl), .ext_en(ext_en),
    .ext_val(ext_val), .pad_level(pad_in));
  always #12.5 mclk = ~mclk;
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) bus_req <= '{a, 1'b1, 1'b0, d};
    @(posedge mclk) bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) bus_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge mclk) bus_req <= '0;
    #1;
    `CHK(bus_rvalid, 1'b1)
    `CHK(bus_rdata, e)
  endtask
  task automatic pulse_halt;
    @(posedge mclk) halt_request <= 1'b1;
    @(posedge mclk) halt_request <= 1'b0;
    #1;
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    bus_req = '0;
    ext_en = 8'hFF;
    ext_val = 8'h00;
    strap_direction = 2'h1;
    strap_output_value = 2'h2;
    comparator_trip = 1'b0;
    trip_wake_select = 1'b0;
    timer_zero_overflow = 1'b0;
    halt_request = 1'b0;
    idle_request = 1'b0;
    idle_timer_wake = 1'b0;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    cyc(2);
    sys_rst <= 1'b0;
    rd(8'hB3, 8'h01);
    rd(8'hB2, 8'h20);
    rd(8'hAF, 8'h00);
    rd(8'hB0, 8'h00);
    rd(8'hB1, 8'h00);
    rd(8'hB6, 8'h00);
    done("reset");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
    end
    done("table");
    wr(8'hB3, 8'h0F);
    ext_en <= 8'h50;
    ext_val <= 8'h40;
    cyc(8);
    `CHK(pad_ctrl.drive_en, 8'h0F)
    `CHK(pad_ctrl.pullup_en, 8'hA0)
    rd(8'hB4, 8'hE5);
    done("pads");
    ext_val <= 8'h50;
    wr(8'hAF, 8'h10);
    wr(8'hB1, 8'h11);
    wr(8'hB6, 8'h80);
    wr(8'hB2, 8'hA4);
    cyc(8);
    wr(8'hB0, 8'h00);
    rd(8'hB0, 8'h00);
    ext_val <= 8'h00;
    wr(8'hB2, 8'hA5);
    cyc(8);
    rd(8'hB0, 8'h11);
    `CHK(shared_edge_irq, 1'b1)
    cyc(10);
    rd(8'hB0, 8'h11);
    pulse_halt();
    `CHK(halt_active, 1'b0)
    wr(8'hB0, 8'hFE);
    rd(8'hB0, 8'h10);
    `CHK(shared_edge_irq, 1'b1)
    wr(8'hB6, 8'h00);
    cyc(2);
    `CHK(shared_edge_irq, 1'b0)
    wr(8'hB0, 8'hEF);
    rd(8'hB0, 8'h00);
    done("wake");
    ext_val <= 8'h10;
    cyc(8);
    rd(8'hB0, 8'h00);
    pulse_halt();
    `CHK(halt_active, 1'b1)
    ext_val <= 8'h00;
    k = 0;
    while (wake_out_a !== 1'b1 && k < 20) begin
      @(posedge mclk);
      #1;
      k++;
    end
    `CHK(wake_out_a, 1'b1)
    `CHK(halt_active, 1'b0)
    wr(8'hB0, 8'h00);
    @(posedge mclk) idle_request <= 1'b1;
    @(posedge mclk) idle_request <= 1'b0;
    #1;
    `CHK(idle_active, 1'b1)
    @(posedge mclk) idle_timer_wake <= 1'b1;
    @(posedge mclk) idle_timer_wake <= 1'b0;
    #1;
    `CHK(idle_active, 1'b0)
    done("halt");
    wr(8'hB1, 8'h40);
    wr(8'hAF, 8'h00);
    comparator_trip <= 1'b1;
    trip_wake_select <= 1'b1;
    cyc(6);
    rd(8'hB0, 8'h00);
    @(posedge mclk) comparator_trip <= 1'b0;
    cyc(3);
    comparator_trip <= 1'b1;
    cyc(3);
    rd(8'hB0, 8'h40);
    done("trip");
    wr(8'hB6, 8'h01);
    @(posedge mclk) timer_zero_overflow <= 1'b1;
    @(posedge mclk) timer_zero_overflow <= 1'b0;
    cyc(2);
    `CHK(timer_zero_irq, 1'b1)
    rd(8'hB6, 8'h03);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    rd(8'hB0, 8'h00);
    rd(8'hB6, 8'h00);
    done("timer and second reset");
    summarize();
  end
endmodule
`default_nettype wire
